// File: drefwm_defines.svh
// Constant macros for the drive reference and warning monitor.
`ifndef DREFWM_DEFINES_SVH
`define DREFWM_DEFINES_SVH
`define DREFWM_ADDR_FUNC 4'h0
`define DREFWM_ADDR_PRESET0 4'h1
`define DREFWM_ADDR_TRIM 4'h5
`define DREFWM_ADDR_CAP 4'h6
`define DREFWM_ADDR_CUR_LO 4'h7
`define DREFWM_ADDR_CUR_HI 4'h8
`define DREFWM_ADDR_FRQ_LO 4'h9
`define DREFWM_ADDR_FRQ_HI 4'hA
`define DREFWM_ADDR_FB_LO 4'hB
`define DREFWM_ADDR_FB_HI 4'hC
`define DREFWM_ADDR_ROUTE 4'hD
`define DREFWM_ADDR_STATUS 4'hE
`define DREFWM_ADDR_REF 4'hF
`define DREFWM_PRESET_RST 32'h0000_0000
`define DREFWM_TRIM_MAX 32'h0000_2710
`define DREFWM_PCT_MAX 32'h0000_2710
`define DREFWM_CAP_RST 32'h0000_3E80
`define DREFWM_FRQ_HI_RST 32'h0002_03A0
`define DREFWM_FRQ_LIM0 32'h0002_03A0
`define DREFWM_FRQ_LIM1 32'h000F_4240
`define DREFWM_FB_LO_RST 32'hFFC2_F700
`define DREFWM_FB_HI_RST 32'h003D_0900
`define DREFWM_FB_MIN 32'hFA0A_1F00
`define DREFWM_FB_MAX 32'h05F5_E100
`define DREFWM_CUR_HI_RST 32'h7FFF_FFFF
`endif

// File: drefwm_pkg.sv
// Types shared by the drive reference and warning monitor.
package drefwm_pkg;
  typedef enum logic [1:0] {
    DREFWM_SUM = 2'b00,
    DREFWM_RELATIVE = 2'b01,
    DREFWM_EXT_PRESET = 2'b10
  } drefwm_func_t;
  typedef enum logic [1:0] {
    DREFWM_STOPPED = 2'b00,
    DREFWM_RAMPING = 2'b01,
    DREFWM_ARMED = 2'b10
  } drefwm_state_t;
endpackage

// File: drefwm_limit.sv
// Window comparator that flags a value below or above two thresholds.
`timescale 1ns/10ps
module drefwm_limit (
  // Value and thresholds.
  input wire logic signed [31:0] i_value,
  input wire logic signed [31:0] i_low,
  input wire logic signed [31:0] i_high,
  // Results.
  output logic o_below,
  output logic o_above
);
  assign o_below = i_value < i_low;
  assign o_above = i_value > i_high;
endmodule

// File: drefwm_top.sv
// Reference combiner, current cap and limit warning monitor.
`timescale 1ns/10ps
`include "drefwm_defines.svh"
// Functional notes
// - Sum mode adds preset percent of reference span to external references.
// - Relative mode adds preset percent of external reference sum.
// - External-or-preset mode: an input picks external or preset span value.
// - In sum or relative mode a preset always contributes; zero is neutral.
// - Four signed presets, +-100.00 percent in hundredths, reset zero.
// - Two select bits, msb first, pick preset one to four.
// - Catch-up adds trim percentage of the reference.
// - Slow-down subtracts the same trim percentage.
// - Remote reference is preset plus analog, pulse and serial parts.
// - Output current cap as percent of rated current, default 160.
// - Low-current warning when current is below its threshold.
// - High-current warning when current is above its threshold.
// - Low-frequency warning when frequency is below its threshold.
// - High-frequency warning above threshold, bounded by 132 or 1000 Hz.
// - Low-feedback warning when feedback is below its threshold.
// - High-feedback warning above threshold, default 4000.
// - Warnings suppressed while ramping after start, and while stopped.
// - Warnings enabled once output frequency reaches resulting reference.
// - Each warning can be routed to signal output and relay.
// - Feedback thresholds ordered, within +-100000.
module drefwm_top
  import drefwm_pkg::*;
(
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_resetn,
  // Register port.
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [31:0] o_rdata,
  // Reference inputs, frequencies in mHz, references signed.
  input wire logic signed [31:0] i_ref_floor,
  input wire logic signed [31:0] i_ref_ceiling,
  input wire logic signed [31:0] i_analog_ref,
  input wire logic signed [31:0] i_pulse_ref,
  input wire logic signed [31:0] i_serial_ref,
  input wire logic [1:0] i_preset_sel,
  input wire logic i_preset_on,
  input wire logic i_catch_up,
  input wire logic i_slow_down,
  // Drive state and measurements.
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_wide_range,
  input wire logic signed [31:0] i_out_freq,
  input wire logic signed [31:0] i_out_current,
  input wire logic signed [31:0] i_feedback,
  // Results.
  output logic signed [31:0] o_reference,
  output logic [31:0] o_current_cap,
  output logic [5:0] o_warnings,
  output logic o_signal_out,
  output logic o_relay_out
);
  logic rst_meta;
  logic rst_n;
  drefwm_func_t func_mode;
  logic signed [31:0] preset [4];
  logic [31:0] trim_percentage;
  logic [31:0] output_current_cap;
  logic signed [31:0] current_low_threshold;
  logic signed [31:0] current_high_threshold;
  logic signed [31:0] freq_low_threshold;
  logic signed [31:0] freq_high_threshold;
  logic signed [31:0] feedback_low_threshold;
  logic signed [31:0] feedback_high_threshold;
  logic [5:0] route_signal;
  logic [5:0] route_relay;
  drefwm_state_t state;
  drefwm_state_t next_state;
  logic signed [31:0] next_reference;
  logic signed [31:0] ext_sum;
  logic signed [31:0] preset_val;
  logic signed [31:0] base;
  logic [5:0] raw;
  logic cur_lo, cur_hi, frq_lo, frq_hi, fb_lo, fb_hi;
  logic signed [31:0] wv;

  // Scale a value by a hundredth-percent figure.
  function automatic logic signed [31:0] pct(input logic signed [31:0] v,
                                             input logic signed [31:0] p);
    logic signed [63:0] prod;
    prod = 64'(v) * 64'(p);
    return 32'(prod / 64'sd10000);
  endfunction

  // Clamp a signed value into a range.
  function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                               input logic signed [31:0] lo,
                                               input logic signed [31:0] hi);
    if (v < lo) begin
      return lo;
    end
    if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  // Reset release through two flops.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  assign wv = $signed(i_wdata);

  // Configuration registers; out-of-range writes are clamped, except cap writes; function code 3 is ignored.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      func_mode <= DREFWM_SUM;
      for (int k = 0; k < 4; k++) begin
        preset[k] <= `DREFWM_PRESET_RST;
      end
      trim_percentage <= 32'h0000_0000;
      output_current_cap <= `DREFWM_CAP_RST;
      current_low_threshold <= 32'h0000_0000;
      current_high_threshold <= `DREFWM_CUR_HI_RST;
      freq_low_threshold <= 32'h0000_0000;
      freq_high_threshold <= `DREFWM_FRQ_HI_RST;
      feedback_low_threshold <= `DREFWM_FB_LO_RST;
      feedback_high_threshold <= `DREFWM_FB_HI_RST;
      route_signal <= 6'h00;
      route_relay <= 6'h00;
    end else if (i_write) begin
      unique case (i_addr)
        `DREFWM_ADDR_FUNC: begin
          if (i_wdata[1:0] != 2'b11) begin
            func_mode <= drefwm_func_t'(i_wdata[1:0]);
          end
        end
        `DREFWM_ADDR_TRIM: begin
          trim_percentage <= (i_wdata > `DREFWM_TRIM_MAX) ?
                             `DREFWM_TRIM_MAX : i_wdata;
        end
        `DREFWM_ADDR_CAP: output_current_cap <= i_wdata;
        `DREFWM_ADDR_CUR_LO: begin
          current_low_threshold <= clamp(wv, 32'sh0, current_high_threshold);
        end
        `DREFWM_ADDR_CUR_HI: begin
          current_high_threshold <= clamp(wv, current_low_threshold,
                                          32'sh7FFF_FFFF);
        end
        `DREFWM_ADDR_FRQ_LO: begin
          freq_low_threshold <= clamp(wv, 32'sh0, freq_high_threshold);
        end
        `DREFWM_ADDR_FRQ_HI: begin
          freq_high_threshold <= clamp(wv, freq_low_threshold,
              i_wide_range ? `DREFWM_FRQ_LIM1 : `DREFWM_FRQ_LIM0);
        end
        `DREFWM_ADDR_FB_LO: begin
          feedback_low_threshold <= clamp(wv, `DREFWM_FB_MIN,
                                          feedback_high_threshold);
        end
        `DREFWM_ADDR_FB_HI: begin
          feedback_high_threshold <= clamp(wv, feedback_low_threshold,
                                           `DREFWM_FB_MAX);
        end
        `DREFWM_ADDR_ROUTE: begin
          route_signal <= i_wdata[5:0];
          route_relay <= i_wdata[13:8];
        end
        default: begin
          if (i_addr >= `DREFWM_ADDR_PRESET0 &&
              i_addr < `DREFWM_ADDR_TRIM) begin
            preset[2'(i_addr - `DREFWM_ADDR_PRESET0)] <=
                clamp(wv, -$signed(`DREFWM_PCT_MAX),
                      $signed(`DREFWM_PCT_MAX));
          end
        end
      endcase
    end
  end

  // Read data stands in the cycle after the strobe only.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (!i_read) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      unique case (i_addr)
        `DREFWM_ADDR_FUNC: o_rdata <= {30'h0, func_mode};
        `DREFWM_ADDR_TRIM: o_rdata <= trim_percentage;
        `DREFWM_ADDR_CAP: o_rdata <= output_current_cap;
        `DREFWM_ADDR_CUR_LO: o_rdata <= current_low_threshold;
        `DREFWM_ADDR_CUR_HI: o_rdata <= current_high_threshold;
        `DREFWM_ADDR_FRQ_LO: o_rdata <= freq_low_threshold;
        `DREFWM_ADDR_FRQ_HI: o_rdata <= freq_high_threshold;
        `DREFWM_ADDR_FB_LO: o_rdata <= feedback_low_threshold;
        `DREFWM_ADDR_FB_HI: o_rdata <= feedback_high_threshold;
        `DREFWM_ADDR_ROUTE: o_rdata <= {18'h0, route_relay, 2'h0,
                                        route_signal};
        `DREFWM_ADDR_STATUS: o_rdata <= {24'h0, state, o_warnings};
        `DREFWM_ADDR_REF: o_rdata <= o_reference;
        default: o_rdata <= preset[2'(i_addr - `DREFWM_ADDR_PRESET0)];
      endcase
    end
  end

  // Reference combination; select msb first indexes presets 1..4.
  always_comb begin
    ext_sum = i_analog_ref + i_pulse_ref + i_serial_ref;
    preset_val = preset[i_preset_sel];
    unique case (func_mode)
      DREFWM_SUM: begin
        base = ext_sum + pct(i_ref_ceiling - i_ref_floor, preset_val);
      end
      DREFWM_RELATIVE: begin
        base = ext_sum + pct(ext_sum, preset_val);
      end
      default: begin
        base = i_preset_on ? pct(i_ref_ceiling - i_ref_floor, preset_val)
                           : ext_sum;
      end
    endcase
    next_reference = base;
    if (i_catch_up && !i_slow_down) begin
      next_reference = base + pct(base, $signed(trim_percentage));
    end else if (i_slow_down && !i_catch_up) begin
      next_reference = base - pct(base, $signed(trim_percentage));
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_reference <= 32'sh0;
      o_current_cap <= `DREFWM_CAP_RST;
    end else begin
      o_reference <= next_reference;
      o_current_cap <= output_current_cap;
    end
  end

  // Warning gate: stopped, ramping after start, armed at reference; stop returns straight to stopped.
  always_comb begin
    next_state = state;
    unique case (state)
      DREFWM_STOPPED: begin
        if (i_start && !i_stop) begin
          next_state = DREFWM_RAMPING;
        end
      end
      DREFWM_RAMPING: begin
        if (i_stop) begin
          next_state = DREFWM_STOPPED;
        end else if (i_out_freq == o_reference) begin
          next_state = DREFWM_ARMED;
        end
      end
      DREFWM_ARMED: begin
        if (i_stop) begin
          next_state = DREFWM_STOPPED;
        end
      end
      default: next_state = DREFWM_STOPPED;
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= DREFWM_STOPPED;
    end else begin
      state <= next_state;
    end
  end

  drefwm_limit u_cur (
    .i_value(i_out_current),
    .i_low(current_low_threshold),
    .i_high(current_high_threshold),
    .o_below(cur_lo),
    .o_above(cur_hi)
  );
  drefwm_limit u_frq (
    .i_value(i_out_freq),
    .i_low(freq_low_threshold),
    .i_high(freq_high_threshold),
    .o_below(frq_lo),
    .o_above(frq_hi)
  );
  drefwm_limit u_fb (
    .i_value(i_feedback),
    .i_low(feedback_low_threshold),
    .i_high(feedback_high_threshold),
    .o_below(fb_lo),
    .o_above(fb_hi)
  );

  assign raw = {fb_hi, fb_lo, frq_hi, frq_lo, cur_hi, cur_lo};

  // Flags are refreshed every cycle so a cleared condition drops at once.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_warnings <= 6'h00;
      o_signal_out <= 1'b0;
      o_relay_out <= 1'b0;
    end else if (state == DREFWM_ARMED && next_state == DREFWM_ARMED) begin
      o_warnings <= raw;
      o_signal_out <= |(raw & route_signal);
      o_relay_out <= |(raw & route_relay);
    end else begin
      o_warnings <= 6'h00;
      o_signal_out <= 1'b0;
      o_relay_out <= 1'b0;
    end
  end

  a_gate_off: assert property (@(posedge i_clock) disable iff (!rst_n)
    state != DREFWM_ARMED |=> o_warnings == 6'h00)
    else $error("warning raised while not armed");
  a_arm_at_ref: assert property (@(posedge i_clock) disable iff (!rst_n)
    state == DREFWM_RAMPING && !i_stop && i_out_freq == o_reference
    |=> state == DREFWM_ARMED)
    else $error("not armed at reference");
  a_cur_low: assert property (@(posedge i_clock) disable iff (!rst_n)
    state == DREFWM_ARMED && !i_stop && i_out_current < current_low_threshold
    |=> o_warnings[0])
    else $error("low current missed");
  a_cur_high: assert property (@(posedge i_clock) disable iff (!rst_n)
    state == DREFWM_ARMED && !i_stop && i_out_current > current_high_threshold
    |=> o_warnings[1])
    else $error("high current missed");
  a_frq_low: assert property (@(posedge i_clock) disable iff (!rst_n)
    state == DREFWM_ARMED && !i_stop && i_out_freq < freq_low_threshold
    |=> o_warnings[2])
    else $error("low frequency missed");
  a_frq_high: assert property (@(posedge i_clock) disable iff (!rst_n)
    state == DREFWM_ARMED && !i_stop && i_out_freq > freq_high_threshold
    |=> o_warnings[3])
    else $error("high frequency missed");
  a_fb_low: assert property (@(posedge i_clock) disable iff (!rst_n)
    state == DREFWM_ARMED && !i_stop && i_feedback < feedback_low_threshold
    |=> o_warnings[4])
    else $error("low feedback missed");
  a_fb_high: assert property (@(posedge i_clock) disable iff (!rst_n)
    state == DREFWM_ARMED && !i_stop && i_feedback > feedback_high_threshold
    |=> o_warnings[5])
    else $error("high feedback missed");
  a_fb_order: assert property (@(posedge i_clock) disable iff (!rst_n)
    feedback_low_threshold <= feedback_high_threshold)
    else $error("feedback thresholds out of order");
  a_stop_clear: assert property (@(posedge i_clock) disable iff (!rst_n)
    i_stop |=> state == DREFWM_STOPPED ##1 o_warnings == 6'h00)
    else $error("stop did not clear warnings");
  c_armed: cover property (@(posedge i_clock) disable iff (!rst_n)
    state == DREFWM_RAMPING ##1 state == DREFWM_ARMED);
  c_warn: cover property (@(posedge i_clock) disable iff (!rst_n)
    o_warnings != 6'h00);
  c_relay: cover property (@(posedge i_clock) disable iff (!rst_n)
    o_relay_out);
endmodule

// File: drefwm_drive_model.sv
// Behavioural drive stage that slews output frequency toward the reference.
`timescale 1ns/10ps
module drefwm_drive_model (
  // Clock and run command.
  input wire logic i_clock,
  input wire logic i_run,
  // Target and slew per cycle.
  input wire logic signed [31:0] i_target,
  input wire logic [31:0] i_step,
  // Output frequency seen by the monitor.
  output logic signed [31:0] o_freq
);
  logic signed [31:0] goal;
  logic signed [31:0] diff;
  // A stopped drive slews down to zero instead of jumping, like a real one.
  assign goal = i_run ? i_target : 32'sh0000_0000;
  assign diff = goal - o_freq;
  initial o_freq = 32'sh0000_0000;
  always @(posedge i_clock) begin
    if (diff > $signed(i_step)) begin
      o_freq <= o_freq + $signed(i_step);
    end else if (diff < -$signed(i_step)) begin
      o_freq <= o_freq - $signed(i_step);
    end else begin
      o_freq <= goal;
    end
  end
endmodule

// File: drefwm_top_test.sv
// Self-checking bench for the reference combiner and warning monitor.
`timescale 1ns/10ps
`include "drefwm_defines.svh"
module drefwm_top_test;
  import drefwm_pkg::*;
  logic clk = 0, rstn = 0, wr_s = 0, rd_s = 0, on = 0, cu = 0, sd = 0;
  logic start = 0, stop = 0, wide = 0, run = 0, sig, rly;
  logic [3:0] addr = 4'h0;
  logic [1:0] sel = 2'h0;
  logic [31:0] wdata = 32'h0, rdata, cap, step = 32'h1F4, rv;
  logic signed [31:0] an = 0, pu = 0, se = 0, cur = 0, fb = 0, frq, ref_o;
  logic signed [31:0] flo = 0, cei = 32'sh0001_86A0;
  logic [5:0] warn;
  int err_total = 0, checked = 0, cycles = 0;
  always #2 clk = ~clk;
  drefwm_drive_model model (.i_clock(clk), .i_run(run), .i_target(ref_o),
    .i_step(step), .o_freq(frq));
  drefwm_top dut (.i_clock(clk), .i_resetn(rstn), .i_addr(addr),
    .i_wdata(wdata), .i_write(wr_s), .i_read(rd_s), .o_rdata(rdata),
    .i_ref_floor(flo), .i_ref_ceiling(cei),
    .i_analog_ref(an), .i_pulse_ref(pu), .i_serial_ref(se),
    .i_preset_sel(sel), .i_preset_on(on), .i_catch_up(cu),
    .i_slow_down(sd), .i_start(start), .i_stop(stop), .i_wide_range(wide),
    .i_out_freq(frq), .i_out_current(cur), .i_feedback(fb),
    .o_reference(ref_o), .o_current_cap(cap), .o_warnings(warn),
    .o_signal_out(sig), .o_relay_out(rly));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1;
    @(posedge clk);
    wr_s <= 0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1;
    @(posedge clk);
    rd_s <= 0;
    #1 d = o_rdata_copy();
  endtask
  function automatic logic [31:0] o_rdata_copy();
    return rdata;
  endfunction
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Percent figures are hundredths, truncated toward zero like the hardware.
  function automatic logic [31:0] exp_ref(input int f, input longint p,
      input longint sp, input longint ext, input logic o, input logic c,
      input logic s, input longint t);
    longint r;
    if (f == 0) r = ext + sp * p / 10000;
    else if (f == 1) r = ext + ext * p / 10000;
    else r = o ? sp * p / 10000 : ext;
    if (c && !s) r = r + r * t / 10000;
    if (s && !c) r = r - r * t / 10000;
    return r[31:0];
  endfunction
  task automatic warn_case(input logic signed [31:0] c, input logic signed
      [31:0] f, input logic [31:0] lo, input logic [31:0] hi,
      input logic [5:0] exp);
    wr(`DREFWM_ADDR_FRQ_LO, lo);
    wr(`DREFWM_ADDR_FRQ_HI, hi);
    cur <= c;
    fb <= f;
    settle(4);
    check(warn, exp);
    check(sig, exp[5]);
    check(rly, exp[0]);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    int f;
    logic [31:0] p, t, e;
    void'($urandom(63));
    repeat (20) @(posedge clk);
    rstn <= 1;
    settle(4);
    check(cap, `DREFWM_CAP_RST);
    rd(`DREFWM_ADDR_FB_HI, rv);
    check(rv, `DREFWM_FB_HI_RST);
    rd(`DREFWM_ADDR_FRQ_HI, rv);
    check(rv, 32'h0002_03A0);
    for (int k = 0; k < 4; k++) begin
      rd(`DREFWM_ADDR_PRESET0 + k[3:0], rv);
      check(rv, `DREFWM_PRESET_RST);
    end
    wr(`DREFWM_ADDR_PRESET0, 32'h0000_4E20);
    rd(`DREFWM_ADDR_PRESET0, rv);
    check(rv, `DREFWM_PCT_MAX);
    wr(`DREFWM_ADDR_CAP, 32'h0000_2710);
    settle(2);
    check(cap, 32'h0000_2710);
    for (int i = 0; i < 45; i++) begin
      f = i % 3;
      p = (int'($urandom % 201) - 100) * 100;
      if (i < 3) p = 10000;
      else if (i < 6) p = -10000;
      t = ($urandom % 101) * 100;
      wr(`DREFWM_ADDR_FUNC, f);
      if (i % 5 == 0) wr(`DREFWM_ADDR_FUNC, 32'h3);
      sel <= 2'($urandom);
      #1 wr(`DREFWM_ADDR_PRESET0 + {2'b00, sel}, p);
      wr(`DREFWM_ADDR_TRIM, t);
      an <= ($urandom % 5) * 10000;
      pu <= ($urandom % 5) * 10000;
      se <= ($urandom % 5) * 10000;
      flo <= ($urandom % 5) * 10000;
      cei <= ($urandom % 5) * 10000 + ($urandom % 3 + 1) * 50000;
      {on, cu, sd} <= 3'($urandom);
      settle(3);
      e = exp_ref(f, $signed(p), cei - flo, an + pu + se, on, cu, sd, t);
      check(ref_o, e);
      rd(`DREFWM_ADDR_REF, rv);
      check(rv, e);
    end
    wr(`DREFWM_ADDR_FUNC, 32'h0);
    wr(`DREFWM_ADDR_PRESET0, 32'h0);
    wr(`DREFWM_ADDR_TRIM, 32'h0);
    sel <= 0;
    {on, cu, sd} <= 0;
    an <= 50000;
    pu <= 0;
    se <= 0;
    wr(`DREFWM_ADDR_CUR_HI, 32'd1500);
    wr(`DREFWM_ADDR_CUR_LO, 32'd1000);
    wr(`DREFWM_ADDR_ROUTE, 32'h0000_0120);
    cur <= 500;
    start <= 1;
    run <= 1;
    @(posedge clk);
    start <= 0;
    settle(40);
    check(warn, 6'h00);
    rd(`DREFWM_ADDR_STATUS, rv);
    check(rv[7:6], DREFWM_RAMPING);
    for (int w = 0; w < 200 && rv[7:6] !== DREFWM_ARMED; w++) begin
      rd(`DREFWM_ADDR_STATUS, rv);
    end
    check(rv[7:6], DREFWM_ARMED);
    warn_case(500, 0, 0, 132000, 6'h01);
    warn_case(2000, 0, 0, 132000, 6'h02);
    warn_case(1200, 0, 60000, 132000, 6'h04);
    warn_case(1200, 0, 0, 40000, 6'h08);
    warn_case(1200, 5000000, 0, 132000, 6'h20);
    warn_case(1200, -5000000, 0, 132000, 6'h10);
    stop <= 1;
    run <= 0;
    settle(2);
    check(warn, 6'h00);
    stop <= 0;
    rd(`DREFWM_ADDR_STATUS, rv);
    check(rv, 32'h0);
    wr(`DREFWM_ADDR_FRQ_HI, 32'd500000);
    rd(`DREFWM_ADDR_FRQ_HI, rv);
    check(rv, `DREFWM_FRQ_LIM0);
    wide <= 1;
    wr(`DREFWM_ADDR_FRQ_HI, 32'd500000);
    rd(`DREFWM_ADDR_FRQ_HI, rv);
    check(rv, 32'd500000);
    wr(`DREFWM_ADDR_FB_HI, 32'h7FFF_0000);
    rd(`DREFWM_ADDR_FB_HI, rv);
    check(rv, `DREFWM_FB_MAX);
    wr(`DREFWM_ADDR_FB_LO, 32'h8000_0000);
    rd(`DREFWM_ADDR_FB_LO, rv);
    check(rv, `DREFWM_FB_MIN);
    give_verdict();
  end
endmodule
